// ===== rtl/lccf_pkg.sv
// constants and types for the linear charge control block
package lccf_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FAST = 8'h01;
  localparam logic [7:0] A_PRE = 8'h02;
  localparam logic [7:0] A_VREG = 8'h03;
  localparam logic [7:0] A_TMR = 8'h04;
  localparam logic [7:0] A_STAT = 8'h05;
  localparam int CTRL_DIS = 0;
  localparam int CTRL_TRK = 1;
  localparam int CTRL_TERM = 2;
  localparam int CTRL_T2X = 3;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] FAST_RST = 8'h10;
  localparam logic [7:0] PRE_RST = 8'h02;
  localparam logic [7:0] VREG_RST = 8'h46;
  localparam logic [7:0] TMR_RST = 8'h06;
  localparam logic [7:0] VREG_MAX = 8'h73;
  localparam logic [7:0] TMR_MIN_H = 8'h03;
  localparam logic [7:0] TMR_MAX_H = 8'h0C;
  localparam int MIN_PER_H = 60;
  localparam int PRE_PCT = 25;
  localparam int TERM_OFF_PCT = 20;
  localparam int TMR_W = 10;
  localparam logic [63:0] CLK_HZ = 64'd50_000_000;
  localparam logic [63:0] MINUTE_S = 64'd60;
  localparam logic [63:0] MINUTE_CYC = CLK_HZ * MINUTE_S;
  localparam logic [1:0] CS_OFF = 2'h0;
  localparam logic [1:0] CS_PRE = 2'h1;
  localparam logic [1:0] CS_FAST = 2'h2;
  localparam logic [1:0] CS_DONE = 2'h3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TRK = 2'h1;
  localparam logic [1:0] MODE_PRE = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
  localparam int F_UVLO = 0;
  localparam int F_SLEEP = 1;
  localparam int F_OVP = 2;
  localparam int F_SC = 3;
  localparam int F_LOWV = 4;
  localparam int F_CV = 5;
  localparam int F_TERM = 6;
  localparam int F_VREGL = 7;
  localparam int F_PRIO = 8;
  localparam int F_INPUT_CURRENT_LIMIT = 9;
  localparam int F_THERM = 10;
  localparam int F_NTC = 11;
  localparam int F_SUPP = 12;
  localparam int F_BATOK = 13;
  localparam int F_RECHG = 14;
  localparam int F_ALLOWN = 15;
  localparam int NF = 16;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_TRK = 6'h02,
    ST_PRE = 6'h04,
    ST_FAST = 6'h08,
    ST_DONE = 6'h10,
    ST_FAULT = 6'h20
  } lccf_state_e;
endpackage : lccf_pkg

// ===== rtl/lccf_safety_timer.sv
// safety timer counting minute ticks against a limit
`timescale 1ns/10ps
module lccf_safety_timer #(
  parameter int CNT_W = lccf_pkg::TMR_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_tick,
  input wire logic i_half,
  input wire logic [CNT_W-1:0] i_limit,
  output logic o_expired
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic phase;
    logic expired;
  } lccf_tmr_s;

  lccf_tmr_s st_ff;
  lccf_tmr_s nxt_st;

  if (CNT_W < 10)
  begin : g_chk
    $error("timer too narrow for the longest limit");
  end

  always_comb
  begin
    nxt_st = st_ff;
    if (i_restart)
    begin
      nxt_st = '0;
    end
    else if (i_tick)
    begin
      nxt_st.phase = ~st_ff.phase;
      // doubled duration: advance on every second tick
      if (!i_half || st_ff.phase)
      begin
        if (st_ff.cnt != {CNT_W{1'b1}})
        begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
    end
    nxt_st.expired = !i_restart && (nxt_st.cnt >= i_limit);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_expired = st_ff.expired;
endmodule : lccf_safety_timer

// ===== rtl/lccf_charge_ctrl.sv
// charge sequencing, enable qualification and registers of the linear charger
//
// Overview of operation
// - charge allowed only with allow pin low and disable bit zero
// - a charge cycle needs a valid input: above lockout, sleep, below overvoltage
// - charging disabled by pin or bit turns the battery switch off
// - below short-circuit threshold the battery charges in trickle mode
// - trickle select bit picks 8 mA or 1 mA trickle current
// - trickle and precharge use a timer of a quarter the fast setting
// - between short-circuit and low-voltage thresholds, charge at precharge current
// - reaching the low-voltage threshold moves to fast charge current
// - with termination disabled, precharge current is a fifth of fast current
// - constant current at full setting unless a loop or temperature limits it
// - constant voltage takes over; termination current sets charge state to done
// - regulation target above 4.65 V is clamped to 4.65 V
// - after termination the battery switch is off, system fed from input
// - termination only in constant voltage, and not while other loops limit
// - after done, falling to recharge threshold restarts charge and timers
// - without input and with battery above lockout, system runs from battery
// - limited input power reduces charge current in favour of the system
// - all current loops stay enabled while charging; dominant loop wins
// - input voltage loop active with double enable doubles the safety timer
// - battery supplementing the system blocks termination
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module lccf_charge_ctrl #(
  parameter logic [63:0] MINUTE_CYCLES = lccf_pkg::MINUTE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  input wire logic i_charge_allow_n,
  input wire logic i_vin_above_uvlo,
  input wire logic i_vin_above_sleep,
  input wire logic i_vin_below_ovp,
  input wire logic i_vbat_below_sc,
  input wire logic i_vbat_below_lowv,
  input wire logic i_cv_loop_active,
  input wire logic i_fast_charge_current_field_at_term,
  input wire logic i_vin_reg_active,
  input wire logic i_sys_prio_active,
  input wire logic i_input_current_limit_active,
  input wire logic i_therm_reg_active,
  input wire logic i_thermistor_limit,
  input wire logic i_supplement_active,
  input wire logic i_vbat_above_uvlo,
  input wire logic i_vbat_below_rechg,
  output logic o_battery_switch_on,
  output logic o_loops_enable,
  output logic [1:0] o_current_mode,
  output logic [7:0] o_current_code,
  output logic o_trickle_8ma,
  output logic [7:0] o_vreg_code,
  output logic o_system_from_input,
  output logic o_system_from_battery,
  output logic [1:0] o_charge_state,
  output logic o_fault
);
  localparam int NF = lccf_pkg::NF;

  if (MINUTE_CYCLES < 64'd2 || MINUTE_CYCLES > 64'h0000_0000_FFFF_FFFF)
  begin : g_chk
    $error("minute prescale out of range");
  end

  typedef struct packed {
    lccf_pkg::lccf_state_e st;
    logic [NF-1:0] s1;
    logic [NF-1:0] s2;
    logic [7:0] ctrl;
    logic [7:0] fast;
    logic [7:0] pre;
    logic [7:0] vreg;
    logic [7:0] tmr;
    logic [31:0] pres;
    logic tick;
    logic restart;
    logic bsw;
    logic loops;
    logic [1:0] mode;
    logic [7:0] cur;
    logic trk8;
    logic [7:0] vregc;
    logic sys_in;
    logic sys_bat;
    logic [1:0] cst;
    logic fault;
    logic [7:0] rd;
  } lccf_ctrl_s;

  lccf_ctrl_s st_ff;
  lccf_ctrl_s nxt_st;
  logic expired;
  logic [NF-1:0] flags_raw;
  logic [lccf_pkg::TMR_W-1:0] limit;

  // entry phase chosen from battery level
  function automatic lccf_pkg::lccf_state_e entry_state(
    input logic below_sc,
    input logic below_lowv
  );
    if (below_sc)
    begin
      return lccf_pkg::ST_TRK;
    end
    else if (below_lowv)
    begin
      return lccf_pkg::ST_PRE;
    end
    return lccf_pkg::ST_FAST;
  endfunction : entry_state

  // clamp a code into [lo, hi]
  function automatic logic [7:0] clamp8(
    input logic [7:0] v,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    if (v < lo)
    begin
      return lo;
    end
    else if (v > hi)
    begin
      return hi;
    end
    return v;
  endfunction : clamp8

  assign flags_raw = {
    i_charge_allow_n, i_vbat_below_rechg, i_vbat_above_uvlo,
    i_supplement_active, i_thermistor_limit, i_therm_reg_active,
    i_input_current_limit_active, i_sys_prio_active, i_vin_reg_active, i_fast_charge_current_field_at_term,
    i_cv_loop_active, i_vbat_below_lowv, i_vbat_below_sc,
    i_vin_below_ovp, i_vin_above_sleep, i_vin_above_uvlo
  };

  // quarter of the fast duration while in trickle or precharge
  always_comb
  begin
    logic [9:0] minutes;
    minutes = 10'(clamp8(st_ff.tmr, lccf_pkg::TMR_MIN_H, lccf_pkg::TMR_MAX_H))
      * 10'(lccf_pkg::MIN_PER_H);
    if (st_ff.st == lccf_pkg::ST_FAST)
    begin
      limit = minutes;
    end
    else
    begin
      // widened product: hours times minutes times percent overflows ten bits
      limit = 10'((20'(minutes) * 20'(lccf_pkg::PRE_PCT)) / 20'd100);
    end
  end

  lccf_safety_timer #(
    .CNT_W(lccf_pkg::TMR_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(st_ff.restart),
    .i_tick(st_ff.tick),
    .i_half(st_ff.s2[lccf_pkg::F_VREGL] && st_ff.ctrl[lccf_pkg::CTRL_T2X]),
    .i_limit(limit),
    .o_expired(expired)
  );

  always_comb
  begin
    logic [NF-1:0] f;
    logic chg_ok;
    logic vin_ok;
    logic go;
    logic term_ok;
    lccf_pkg::lccf_state_e ent;
    f = st_ff.s2;
    nxt_st = st_ff;
    nxt_st.s1 = flags_raw;
    // first stage feeds only the second
    nxt_st.s2 = st_ff.s1;
    chg_ok = !f[lccf_pkg::F_ALLOWN] && !st_ff.ctrl[lccf_pkg::CTRL_DIS];
    vin_ok = f[lccf_pkg::F_UVLO] && f[lccf_pkg::F_SLEEP] && f[lccf_pkg::F_OVP];
    go = chg_ok && vin_ok;
    // any limiting loop means the taper is not the battery's own
    term_ok = f[lccf_pkg::F_CV] && f[lccf_pkg::F_TERM]
      && st_ff.ctrl[lccf_pkg::CTRL_TERM]
      && !f[lccf_pkg::F_VREGL] && !f[lccf_pkg::F_PRIO]
      && !f[lccf_pkg::F_INPUT_CURRENT_LIMIT] && !f[lccf_pkg::F_THERM]
      && !f[lccf_pkg::F_SUPP];
    ent = entry_state(f[lccf_pkg::F_SC], f[lccf_pkg::F_LOWV]);
    nxt_st.restart = 1'b0;
    nxt_st.tick = 1'b0;
    if (st_ff.pres >= 32'(MINUTE_CYCLES - 64'd1))
    begin
      nxt_st.pres = '0;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.pres = st_ff.pres + 32'd1;
    end

    unique case (st_ff.st)
      lccf_pkg::ST_IDLE:
      begin
        nxt_st.restart = 1'b1;
        if (go)
        begin
          nxt_st.st = ent;
        end
      end
      lccf_pkg::ST_TRK:
      begin
        if (!go)
        begin
          nxt_st.st = lccf_pkg::ST_IDLE;
        end
        else if (expired)
        begin
          nxt_st.st = lccf_pkg::ST_FAULT;
        end
        else if (!f[lccf_pkg::F_SC])
        begin
          nxt_st.st = lccf_pkg::ST_PRE;
        end
      end
      lccf_pkg::ST_PRE:
      begin
        if (!go)
        begin
          nxt_st.st = lccf_pkg::ST_IDLE;
        end
        else if (expired)
        begin
          nxt_st.st = lccf_pkg::ST_FAULT;
        end
        else if (f[lccf_pkg::F_SC])
        begin
          nxt_st.st = lccf_pkg::ST_TRK;
        end
        else if (!f[lccf_pkg::F_LOWV])
        begin
          nxt_st.st = lccf_pkg::ST_FAST;
          nxt_st.restart = 1'b1;
        end
      end
      lccf_pkg::ST_FAST:
      begin
        if (!go)
        begin
          nxt_st.st = lccf_pkg::ST_IDLE;
        end
        else if (term_ok)
        begin
          nxt_st.st = lccf_pkg::ST_DONE;
        end
        else if (expired)
        begin
          nxt_st.st = lccf_pkg::ST_FAULT;
        end
      end
      lccf_pkg::ST_DONE:
      begin
        if (!go)
        begin
          nxt_st.st = lccf_pkg::ST_IDLE;
        end
        else if (f[lccf_pkg::F_RECHG])
        begin
          nxt_st.st = ent;
          nxt_st.restart = 1'b1;
        end
      end
      lccf_pkg::ST_FAULT:
      begin
        // latched until charging is disabled or the input goes invalid
        if (!go)
        begin
          nxt_st.st = lccf_pkg::ST_IDLE;
        end
      end
      default:
      begin
        nxt_st.st = lccf_pkg::ST_IDLE;
      end
    endcase

    // register writes
    if (i_wr)
    begin
      unique case (i_addr)
        lccf_pkg::A_CTRL: nxt_st.ctrl = {4'h0, i_wr_data[3:0]};
        lccf_pkg::A_FAST: nxt_st.fast = i_wr_data;
        lccf_pkg::A_PRE: nxt_st.pre = i_wr_data;
        lccf_pkg::A_VREG: nxt_st.vreg = i_wr_data;
        lccf_pkg::A_TMR: nxt_st.tmr = i_wr_data;
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end

    // read data stand one cycle, zero otherwise
    nxt_st.rd = '0;
    if (i_rd)
    begin
      unique case (i_addr)
        lccf_pkg::A_CTRL: nxt_st.rd = st_ff.ctrl;
        lccf_pkg::A_FAST: nxt_st.rd = st_ff.fast;
        lccf_pkg::A_PRE: nxt_st.rd = st_ff.pre;
        lccf_pkg::A_VREG: nxt_st.rd = st_ff.vreg;
        lccf_pkg::A_TMR: nxt_st.rd = st_ff.tmr;
        lccf_pkg::A_STAT:
        begin
          nxt_st.rd = {2'h0, chg_ok, vin_ok, st_ff.bsw, st_ff.fault, st_ff.cst};
        end
        default: nxt_st.rd = '0;
      endcase
    end

    // outputs follow the next state so they leave flops with it
    nxt_st.bsw = 1'b0;
    nxt_st.loops = 1'b0;
    nxt_st.mode = lccf_pkg::MODE_OFF;
    nxt_st.cur = '0;
    nxt_st.cst = lccf_pkg::CS_OFF;
    nxt_st.fault = (nxt_st.st == lccf_pkg::ST_FAULT);
    unique case (nxt_st.st)
      lccf_pkg::ST_TRK:
      begin
        nxt_st.bsw = 1'b1;
        nxt_st.mode = lccf_pkg::MODE_TRK;
        nxt_st.cst = lccf_pkg::CS_PRE;
      end
      lccf_pkg::ST_PRE:
      begin
        nxt_st.bsw = 1'b1;
        nxt_st.mode = lccf_pkg::MODE_PRE;
        nxt_st.cst = lccf_pkg::CS_PRE;
        if (st_ff.ctrl[lccf_pkg::CTRL_TERM])
        begin
          nxt_st.cur = st_ff.pre;
        end
        else
        begin
          nxt_st.cur = 8'((16'(st_ff.fast) * 16'(lccf_pkg::TERM_OFF_PCT))
            / 16'd100);
        end
      end
      lccf_pkg::ST_FAST:
      begin
        nxt_st.bsw = 1'b1;
        nxt_st.mode = lccf_pkg::MODE_FAST;
        // full setting; analogue loops pull it down as they dominate
        nxt_st.cur = st_ff.fast;
        nxt_st.cst = lccf_pkg::CS_FAST;
      end
      lccf_pkg::ST_DONE:
      begin
        nxt_st.cst = lccf_pkg::CS_DONE;
      end
      default:
      begin
        nxt_st.bsw = 1'b0;
      end
    endcase
    // every current loop armed together while the switch conducts
    nxt_st.loops = nxt_st.bsw;
    nxt_st.trk8 = st_ff.ctrl[lccf_pkg::CTRL_TRK];
    nxt_st.vregc = clamp8(st_ff.vreg, 8'h00, lccf_pkg::VREG_MAX);
    // done state keeps switch off; system stays on the input
    nxt_st.sys_in = vin_ok;
    nxt_st.sys_bat = !vin_ok && f[lccf_pkg::F_BATOK];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.st <= lccf_pkg::ST_IDLE;
      st_ff.s1 <= '0;
      st_ff.s2 <= '0;
      st_ff.ctrl <= lccf_pkg::CTRL_RST;
      st_ff.fast <= lccf_pkg::FAST_RST;
      st_ff.pre <= lccf_pkg::PRE_RST;
      st_ff.vreg <= lccf_pkg::VREG_RST;
      st_ff.tmr <= lccf_pkg::TMR_RST;
      st_ff.vregc <= lccf_pkg::VREG_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_rd_data = st_ff.rd;
  assign o_battery_switch_on = st_ff.bsw;
  assign o_loops_enable = st_ff.loops;
  assign o_current_mode = st_ff.mode;
  assign o_current_code = st_ff.cur;
  assign o_trickle_8ma = st_ff.trk8;
  assign o_vreg_code = st_ff.vregc;
  assign o_system_from_input = st_ff.sys_in;
  assign o_system_from_battery = st_ff.sys_bat;
  assign o_charge_state = st_ff.cst;
  assign o_fault = st_ff.fault;
endmodule : lccf_charge_ctrl

// ===== sim/lccf_batt_model.sv
// behavioural battery and adapter model driving the comparator flags
`timescale 1ns/10ps
module lccf_batt_model (
  input wire logic [2:0] i_level,
  input wire logic [1:0] i_in_mode,
  output logic o_vin_above_uvlo,
  output logic o_vin_above_sleep,
  output logic o_vin_below_ovp,
  output logic o_vbat_below_sc,
  output logic o_vbat_below_lowv,
  output logic o_cv_loop_active,
  output logic o_fast_charge_current_field_at_term,
  output logic o_vbat_above_uvlo,
  output logic o_vbat_below_rechg
);
  // levels: 0 short, 1 low, 2 cc, 3 cv taper, 4 at term, 5 rested, 6 sagged
  // in modes: 0 valid, 1 under lockout, 2 sleep, 3 overvoltage
  assign o_vin_above_uvlo = i_in_mode != 2'h1;
  assign o_vin_above_sleep = i_in_mode != 2'h2;
  assign o_vin_below_ovp = i_in_mode != 2'h3;
  assign o_vbat_below_sc = i_level == 3'h0;
  assign o_vbat_below_lowv = i_level < 3'h2;
  assign o_cv_loop_active = i_level == 3'h3 || i_level == 3'h4;
  assign o_fast_charge_current_field_at_term = i_level == 3'h4;
  assign o_vbat_above_uvlo = i_level != 3'h0;
  assign o_vbat_below_rechg = i_level < 3'h3 || i_level == 3'h6;
endmodule : lccf_batt_model

// ===== sim/lccf_chk.sv
// concurrent checks on the charge control ports
`timescale 1ns/10ps
module lccf_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_charge_allow_n,
  input wire logic i_vin_above_uvlo,
  input wire logic i_vin_above_sleep,
  input wire logic i_vin_below_ovp,
  input wire logic i_cv_loop_active,
  input wire logic i_fast_charge_current_field_at_term,
  input wire logic i_vin_reg_active,
  input wire logic i_sys_prio_active,
  input wire logic i_input_current_limit_active,
  input wire logic i_therm_reg_active,
  input wire logic i_supplement_active,
  input wire logic i_vbat_above_uvlo,
  input wire logic i_vbat_below_rechg,
  input wire logic o_battery_switch_on,
  input wire logic o_loops_enable,
  input wire logic [1:0] o_current_mode,
  input wire logic [7:0] o_current_code,
  input wire logic [7:0] o_vreg_code,
  input wire logic o_system_from_input,
  input wire logic o_system_from_battery,
  input wire logic [1:0] o_charge_state,
  input wire logic o_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire vin_ok = i_vin_above_uvlo & i_vin_above_sleep & i_vin_below_ovp;
  wire busy = i_vin_reg_active | i_sys_prio_active | i_input_current_limit_active | i_therm_reg_active
    | i_supplement_active;
  // four samples cover the two sync flops plus the state update
  sequence off_cause;
    (i_charge_allow_n || !vin_ok) [*4];
  endsequence
  sequence term_blocked;
    (!i_cv_loop_active || !i_fast_charge_current_field_at_term || busy) [*3];
  endsequence
  sw_off_a: assert property (off_cause |-> !o_battery_switch_on && o_current_mode == 2'h0)
    else $error("switch on while charging disabled");
  loops_en_a: assert property (o_loops_enable == o_battery_switch_on)
    else $error("loop enable differs from switch");
  trickle_a: assert property (o_current_mode == lccf_pkg::MODE_TRK |->
    o_current_code == 8'h00 && o_charge_state == lccf_pkg::CS_PRE)
    else $error("trickle with wrong code or state");
  fast_on_a: assert property (o_current_mode == lccf_pkg::MODE_FAST |->
    o_charge_state == lccf_pkg::CS_FAST && o_battery_switch_on)
    else $error("fast mode without switch");
  done_off_a: assert property (o_charge_state == lccf_pkg::CS_DONE |->
    !o_battery_switch_on && o_current_code == 8'h00)
    else $error("switch on after done");
  fault_off_a: assert property (o_fault |-> !o_battery_switch_on && o_current_mode == 2'h0)
    else $error("charging during fault");
  vreg_clamp_a: assert property (o_vreg_code <= lccf_pkg::VREG_MAX)
    else $error("regulation code above clamp");
  no_term_a: assert property (term_blocked ##0 o_charge_state == lccf_pkg::CS_FAST |=>
    o_charge_state != lccf_pkg::CS_DONE)
    else $error("termination while blocked");
  recharge_a: assert property (o_charge_state == lccf_pkg::CS_DONE && i_vbat_below_rechg |->
    ##[1:4] o_charge_state != lccf_pkg::CS_DONE)
    else $error("no restart at recharge level");
  sys_bat_a: assert property ((!vin_ok && i_vbat_above_uvlo) [*4] |->
    o_system_from_battery && !o_system_from_input)
    else $error("system not on battery");
  sys_in_a: assert property (vin_ok [*4] |-> o_system_from_input && !o_system_from_battery)
    else $error("system not on input");
endmodule : lccf_chk
bind lccf_charge_ctrl lccf_chk chk_u (.i_clk, .i_rst_n, .i_charge_allow_n, .i_vin_above_uvlo,
  .i_vin_above_sleep, .i_vin_below_ovp, .i_cv_loop_active, .i_fast_charge_current_field_at_term, .i_vin_reg_active,
  .i_sys_prio_active, .i_input_current_limit_active, .i_therm_reg_active, .i_supplement_active,
  .i_vbat_above_uvlo, .i_vbat_below_rechg, .o_battery_switch_on, .o_loops_enable,
  .o_current_mode, .o_current_code, .o_vreg_code, .o_system_from_input, .o_system_from_battery,
  .o_charge_state, .o_fault);

// ===== sim/lccf_charge_ctrl_test.sv
// self-checking bench for the charge control block
`timescale 1ns/10ps
module lccf_charge_ctrl_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic allow_n = 1'b1;
  logic [2:0] lvl = 3'h2;
  logic [1:0] inm = 2'h0;
  logic [4:0] loops = 5'h00;
  logic ntc = 1'b0;
  logic [7:0] rdat, code, vreg;
  logic f_uv, f_sl, f_ov, f_sc, f_lv, f_cv, f_tm, f_bu, f_rc;
  logic sw, t8, sfi, sfb, flt;
  logic [1:0] mode, cst;
  int err_total = 0;
  int compares = 0;
  always #10 i_clk = ~i_clk;
  // short minute so timer expiry fits in a few hundred cycles
  lccf_charge_ctrl #(.MINUTE_CYCLES(64'h0000_0000_0000_0004)) dut_u (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(addr), .i_wr_data(wdat), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat),
    .i_charge_allow_n(allow_n), .i_vin_above_uvlo(f_uv), .i_vin_above_sleep(f_sl),
    .i_vin_below_ovp(f_ov), .i_vbat_below_sc(f_sc), .i_vbat_below_lowv(f_lv),
    .i_cv_loop_active(f_cv), .i_fast_charge_current_field_at_term(f_tm), .i_vin_reg_active(loops[0]),
    .i_sys_prio_active(loops[1]), .i_input_current_limit_active(loops[2]), .i_therm_reg_active(loops[3]),
    .i_thermistor_limit(ntc), .i_supplement_active(loops[4]), .i_vbat_above_uvlo(f_bu),
    .i_vbat_below_rechg(f_rc), .o_battery_switch_on(sw), .o_loops_enable(),
    .o_current_mode(mode), .o_current_code(code), .o_trickle_8ma(t8), .o_vreg_code(vreg),
    .o_system_from_input(sfi), .o_system_from_battery(sfb), .o_charge_state(cst), .o_fault(flt));
  lccf_batt_model part_u (.i_level(lvl), .i_in_mode(inm), .o_vin_above_uvlo(f_uv),
    .o_vin_above_sleep(f_sl), .o_vin_below_ovp(f_ov), .o_vbat_below_sc(f_sc),
    .o_vbat_below_lowv(f_lv), .o_cv_loop_active(f_cv), .o_fast_charge_current_field_at_term(f_tm),
    .o_vbat_above_uvlo(f_bu), .o_vbat_below_rechg(f_rc));
  task automatic final_report;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    chk(rdat & m, e);
  endtask : rdc
  task automatic go(input logic [2:0] l, input logic n, input int w);
    @(posedge i_clk);
    lvl <= l;
    allow_n <= n;
    loops <= 5'h00;
    repeat (w) @(negedge i_clk);
  endtask : go
  task automatic st(input logic [1:0] c, input logic [1:0] m, input logic s, input logic [7:0] k);
    chk({3'h0, sw, mode, cst}, {3'h0, s, m, c});
    chk(code, k);
  endtask : st
  task automatic t_regs;
    rdc(lccf_pkg::A_CTRL, 8'hFF, lccf_pkg::CTRL_RST);
    rdc(lccf_pkg::A_FAST, 8'hFF, lccf_pkg::FAST_RST);
    rdc(lccf_pkg::A_PRE, 8'hFF, lccf_pkg::PRE_RST);
    rdc(lccf_pkg::A_VREG, 8'hFF, lccf_pkg::VREG_RST);
    rdc(lccf_pkg::A_TMR, 8'hFF, lccf_pkg::TMR_RST);
    rdc(8'h06, 8'hFF, 8'h00);
    wrr(lccf_pkg::A_CTRL, 8'hF4);
    rdc(lccf_pkg::A_CTRL, 8'hFF, 8'h04);
    for (int i = 0; i < 3; i++)
    begin
      wrr(lccf_pkg::A_VREG, 8'h72 + 8'(i));
      repeat (3) @(negedge i_clk);
      chk(vreg, (i == 2) ? lccf_pkg::VREG_MAX : 8'h72 + 8'(i));
    end
  endtask : t_regs
  task automatic t_enable;
    wrr(lccf_pkg::A_FAST, 8'h32);
    for (int i = 0; i < 4; i++)
    begin
      wrr(lccf_pkg::A_CTRL, {7'h02, i[0]});
      go(3'h2, 1'b1, 5);
      go(3'h2, i[1], 6);
      if (i == 0)
        st(lccf_pkg::CS_FAST, lccf_pkg::MODE_FAST, 1'b1, 8'h32);
      else
        st(lccf_pkg::CS_OFF, lccf_pkg::MODE_OFF, 1'b0, 8'h00);
    end
    // charging enabled, so only the bad input can keep the switch off
    wrr(lccf_pkg::A_CTRL, 8'h04);
    for (int m = 1; m < 4; m++)
    begin
      @(posedge i_clk);
      inm <= 2'(m);
      allow_n <= 1'b0;
      repeat (6) @(negedge i_clk);
      st(lccf_pkg::CS_OFF, lccf_pkg::MODE_OFF, 1'b0, 8'h00);
      chk({6'h00, sfi, sfb}, 8'h01);
    end
    @(posedge i_clk);
    inm <= 2'h0;
  endtask : t_enable
  task automatic t_seq;
    wrr(lccf_pkg::A_CTRL, 8'h06);
    go(3'h0, 1'b1, 5);
    go(3'h0, 1'b0, 6);
    st(lccf_pkg::CS_PRE, lccf_pkg::MODE_TRK, 1'b1, 8'h00);
    chk({7'h00, t8}, 8'h01);
    wrr(lccf_pkg::A_CTRL, 8'h04);
    repeat (3) @(negedge i_clk);
    chk({7'h00, t8}, 8'h00);
    go(3'h1, 1'b0, 6);
    st(lccf_pkg::CS_PRE, lccf_pkg::MODE_PRE, 1'b1, lccf_pkg::PRE_RST);
    // termination off: precharge is a fifth of 0x32, truncated
    wrr(lccf_pkg::A_CTRL, 8'h00);
    repeat (4) @(negedge i_clk);
    chk(code, 8'h0A);
    wrr(lccf_pkg::A_CTRL, 8'h04);
    go(3'h2, 1'b0, 6);
    @(posedge i_clk);
    loops <= 5'h0F;
    ntc <= 1'b1;
    repeat (6) @(negedge i_clk);
    st(lccf_pkg::CS_FAST, lccf_pkg::MODE_FAST, 1'b1, 8'h32);
    @(posedge i_clk);
    ntc <= 1'b0;
  endtask : t_seq
  task automatic t_term;
    go(3'h2, 1'b1, 5);
    go(3'h2, 1'b0, 6);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge i_clk);
      loops <= 5'h01 << i;
      lvl <= 3'h4;
      repeat (6) @(negedge i_clk);
      st(lccf_pkg::CS_FAST, lccf_pkg::MODE_FAST, 1'b1, 8'h32);
    end
    go(3'h3, 1'b0, 6);
    st(lccf_pkg::CS_FAST, lccf_pkg::MODE_FAST, 1'b1, 8'h32);
    go(3'h4, 1'b0, 6);
    st(lccf_pkg::CS_DONE, lccf_pkg::MODE_OFF, 1'b0, 8'h00);
    chk({7'h00, sfi}, 8'h01);
    go(3'h5, 1'b0, 6);
    st(lccf_pkg::CS_DONE, lccf_pkg::MODE_OFF, 1'b0, 8'h00);
    go(3'h6, 1'b0, 6);
    st(lccf_pkg::CS_FAST, lccf_pkg::MODE_FAST, 1'b1, 8'h32);
  endtask : t_term
  // precharge until expiry; counts cycles from the allow edge
  task automatic t_timer(input logic [7:0] ctl, input logic vr, input int lo, input int hi);
    int n = 0;
    wrr(lccf_pkg::A_CTRL, ctl);
    go(3'h1, 1'b1, 5);
    @(posedge i_clk);
    allow_n <= 1'b0;
    loops <= {4'h0, vr};
    while (flt !== 1'b1 && n < hi)
    begin
      @(negedge i_clk);
      n++;
    end
    if (n >= hi)
    begin
      err_total++;
      $display("unexpected at %0t: no expiry", $time);
      final_report();
    end
    chk({7'h00, n >= lo}, 8'h01);
    rdc(lccf_pkg::A_STAT, 8'h0C, 8'h04);
  endtask : t_timer
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_enable();
    t_seq();
    t_term();
    wrr(lccf_pkg::A_TMR, lccf_pkg::TMR_MIN_H);
    // three hours: quarter is 45 ticks of 4 cycles, doubled 90
    t_timer(8'h04, 1'b0, 170, 200);
    t_timer(8'h0C, 1'b1, 340, 390);
    final_report();
  end
endmodule : lccf_charge_ctrl_test
